/* io_port_consts.vh */
`ifndef IO_PORT_CONSTS_VH
`define IO_PORT_CONSTS_VH

// Register map, one aligned word per register
`define GRP_LATCH            2'd0
`define GRP_MODE_A           2'd1
`define GRP_MODE_B           2'd2
`define GRP_MISC             2'd3
`define OFS_LATCH_BASE       8'h00
`define OFS_MODE_A_BASE      8'h10
`define OFS_MODE_B_BASE      8'h20
`define OFS_AIN_DISABLE      8'h30
`define OFS_PIN_COUNT        8'h34
`define MISC_IDX_AIN_DISABLE 2'd0
`define MISC_IDX_PIN_COUNT   2'd1

// Pin geometry
`define NUM_PINS             26
`define NUM_PORTS            4
`define PORT3_WIDTH          2

// Reset values
`define RST_LATCH            26'h3ffffff
`define RST_MODE_A           26'h3ffffff
`define RST_MODE_B           26'h0000000
`define RST_AIN_DISABLE      8'h00
`define AIN_DISABLE_MASK     8'h3e

// Mode encodings {mode_a, mode_b}
`define MODE_QUASI           2'b00
`define MODE_PUSH_PULL       2'b01
`define MODE_INPUT_ONLY      2'b10
`define MODE_OPEN_DRAIN      2'b11

// Special pin positions (flat index = port*8 + bit)
`define PIN_RESET_SHARED     13
`define PIN_I2C_CLOCK        10
`define PIN_I2C_DATA         11
`define PIN_XTAL2            24
`define PIN_XTAL1            25
`define LOCK_INPUT_MASK      26'h0002000
`define I2C_PIN_MASK         26'h0000c00

// Clock source selections
`define CLK_SRC_INTERNAL     2'd0
`define CLK_SRC_EXT_CLOCK    2'd1
`define CLK_SRC_CRYSTAL      2'd2

// Pin counts and timing
`define MAX_IO_PINS          5'd26
`define STRONG_PULSE_CYCLES  2'd2

`endif

/* io_port_block.v */
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "io_port_consts.vh"

module io_port_block (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [1:0]  clk_src_sel,
  input  wire        ext_reset_en,
  input  wire [25:0] pin_in,
  output reg  [25:0] pin_out,
  output reg  [25:0] pin_oe,
  output reg  [25:0] weak_pu_en,
  output reg  [25:0] very_weak_pu_en,
  output reg  [25:0] digital_in_en
);

  // Replace the slice of one port inside a flat pin vector
  function [25:0] put_port;
    input [25:0] old;
    input [7:0]  wdata;
    input [1:0]  port;
    integer i;
    begin
      put_port = old;
      for (i = 0; i < `NUM_PINS; i = i + 1) begin
        if (i[4:3] == port)
          put_port[i] = wdata[i[2:0]];
      end
    end
  endfunction

  // Pick the slice of one port out of a flat pin vector
  function [7:0] get_port;
    input [25:0] v;
    input [1:0]  port;
    integer i;
    begin
      get_port = 8'h00;
      for (i = 0; i < `NUM_PINS; i = i + 1) begin
        if (i[4:3] == port)
          get_port[i[2:0]] = v[i];
      end
    end
  endfunction

  reg  [25:0] latch_q;
  reg  [25:0] latch_prev_q;
  reg  [25:0] mode_a_q;
  reg  [25:0] mode_b_q;
  reg  [7:0]  ain_dis_q;
  reg  [1:0]  clk_src_q;
  reg         ext_reset_q;
  reg  [25:0] sync1_q;
  reg  [25:0] sync2_q;
  reg  [25:0] sync3_q;
  reg  [25:0] filt_q;
  reg  [25:0] lost_pins;
  reg  [4:0]  pin_count;
  reg  [31:0] rdata_d;
  reg         addr_ok;
  reg  [25:0] pin_out_d;
  reg  [25:0] pin_oe_d;
  reg  [25:0] weak_d;
  reg  [25:0] vweak_d;
  reg  [25:0] dis_pins;
  reg  [25:0] mode_a_w;
  reg  [25:0] mode_b_w;

  wire [1:0]  grp      = paddr[5:4];
  wire [1:0]  port_sel = paddr[3:2];
  wire        setup    = psel & ~penable & ~pready;
  wire        access   = psel & penable & pready;
  wire        wr_en    = access & pwrite & addr_ok;

  // Straps from same-clock configuration logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_src_q   <= `CLK_SRC_INTERNAL;
      ext_reset_q <= 1'b0;
    end else begin
      clk_src_q   <= clk_src_sel;
      ext_reset_q <= ext_reset_en;
    end
  end

  // Pins taken by the clock source or the external reset
  always @* begin
    lost_pins = 26'h0000000;
    pin_count = `MAX_IO_PINS;
    if (ext_reset_q) begin
      lost_pins[`PIN_RESET_SHARED] = 1'b1;
      pin_count = pin_count - 5'd1;
    end
    if (clk_src_q == `CLK_SRC_EXT_CLOCK) begin
      lost_pins[`PIN_XTAL1] = 1'b1;
      pin_count = pin_count - 5'd1;
    end else if (clk_src_q == `CLK_SRC_CRYSTAL) begin
      lost_pins[`PIN_XTAL1] = 1'b1;
      lost_pins[`PIN_XTAL2] = 1'b1;
      pin_count = pin_count - 5'd2;
    end
  end

  // Address decode and read mux
  always @* begin
    addr_ok = 1'b1;
    rdata_d = 32'h00000000;
    case (grp)
      `GRP_LATCH: begin
        // Port read returns filtered pin level, masked when input disabled
        rdata_d[7:0] = get_port(filt_q & ~dis_pins, port_sel);
      end
      `GRP_MODE_A: begin
        rdata_d[7:0] = get_port(mode_a_q, port_sel);
      end
      `GRP_MODE_B: begin
        rdata_d[7:0] = get_port(mode_b_q, port_sel);
      end
      `GRP_MISC: begin
        if (port_sel == `MISC_IDX_AIN_DISABLE)
          rdata_d[7:0] = ain_dis_q;
        else if (port_sel == `MISC_IDX_PIN_COUNT)
          rdata_d[4:0] = pin_count;
        else
          addr_ok = 1'b0;
      end
      default: addr_ok = 1'b0;
    endcase
    if (paddr[7:6] != 2'b00 || paddr[1:0] != 2'b00)
      addr_ok = 1'b0;
  end

  // APB answer: ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup && !pwrite)
        prdata <= addr_ok ? rdata_d : 32'h00000000;
    end
  end

  // Write data for mode registers with locked pins held
  always @* begin
    mode_a_w = put_port(mode_a_q, pwdata[7:0], port_sel);
    mode_b_w = put_port(mode_b_q, pwdata[7:0], port_sel);
    mode_a_w = mode_a_w | `LOCK_INPUT_MASK;
    mode_b_w = mode_b_w & ~`LOCK_INPUT_MASK;
    mode_a_w = mode_a_w | `I2C_PIN_MASK;
  end

  // Register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q   <= `RST_LATCH;
      mode_a_q  <= `RST_MODE_A;
      mode_b_q  <= `RST_MODE_B;
      ain_dis_q <= `RST_AIN_DISABLE;
    end else if (wr_en) begin
      case (grp)
        `GRP_LATCH:  latch_q  <= put_port(latch_q, pwdata[7:0], port_sel);
        `GRP_MODE_A: mode_a_q <= mode_a_w;
        `GRP_MODE_B: mode_b_q <= mode_b_w;
        `GRP_MISC: begin
          if (port_sel == `MISC_IDX_AIN_DISABLE)
            ain_dis_q <= pwdata[7:0] & `AIN_DISABLE_MASK;
        end
        default: latch_q <= latch_q;
      endcase
    end
  end

  // Three-stage sampler; level accepted once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 26'h0000000;
      sync2_q <= 26'h0000000;
      sync3_q <= 26'h0000000;
      filt_q  <= 26'h0000000;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
    end
  end

  // Port-0 pins with digital input switched off
  always @* begin
    dis_pins = 26'h0000000;
    dis_pins[7:0] = ain_dis_q & `AIN_DISABLE_MASK;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      latch_prev_q <= `RST_LATCH;
    else
      latch_prev_q <= latch_q;
  end

  // Per-pin drive control
  genvar g;
  generate
    for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_pin
      reg  [1:0] pulse_q;
      wire [1:0] mode  = lost_pins[g] ? `MODE_INPUT_ONLY : {mode_a_q[g], mode_b_q[g]};
      wire       rise  = latch_q[g] & ~latch_prev_q[g];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pulse_q <= 2'd0;
        else if (mode == `MODE_QUASI && rise)
          pulse_q <= `STRONG_PULSE_CYCLES - 2'd1;
        else if (pulse_q != 2'd0)
          pulse_q <= pulse_q - 2'd1;
      end

      always @* begin
        pin_out_d[g] = 1'b0;
        pin_oe_d[g]  = 1'b0;
        weak_d[g]    = 1'b0;
        vweak_d[g]   = 1'b0;
        case (mode)
          `MODE_QUASI: begin
            pin_out_d[g] = latch_q[g];
            // Rise cycle plus counter keeps the drive on with no gap
            pin_oe_d[g]  = ~latch_q[g] | rise | (pulse_q != 2'd0);
            vweak_d[g]   = latch_q[g];
            weak_d[g]    = latch_q[g] & filt_q[g];
          end
          `MODE_PUSH_PULL: begin
            pin_out_d[g] = latch_q[g];
            pin_oe_d[g]  = 1'b1;
          end
          `MODE_OPEN_DRAIN: begin
            pin_out_d[g] = 1'b0;
            pin_oe_d[g]  = ~latch_q[g];
          end
          default: begin
            pin_oe_d[g]  = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // Registered pin-side outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out         <= 26'h0000000;
      pin_oe          <= 26'h0000000;
      weak_pu_en      <= 26'h0000000;
      very_weak_pu_en <= 26'h0000000;
      digital_in_en   <= 26'h3ffffff;
    end else begin
      pin_out         <= pin_out_d;
      pin_oe          <= pin_oe_d;
      weak_pu_en      <= weak_d;
      very_weak_pu_en <= vweak_d;
      digital_in_en   <= ~dis_pins;
    end
  end

endmodule // io_port_block

/* io_port_checker.sv */
`timescale 1ns/10ps
`include "io_port_consts.vh"
module io_port_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic        pready,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [25:0] pin_in,
  input logic [25:0] pin_out,
  input logic [25:0] pin_oe,
  input logic [25:0] weak_pu_en,
  input logic [25:0] very_weak_pu_en
);
  logic       lat_q;
  logic [1:0] mode_q;
  wire        wr = psel && penable && pready && pwrite;
  wire        qb = mode_q == `MODE_QUASI;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pin 0 latch and mode as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q  <= 1'b1;
      mode_q <= `MODE_INPUT_ONLY;
    end else if (wr && paddr == 8'h00) begin
      lat_q <= pwdata[0];
    end else if (wr && paddr == 8'h10) begin
      mode_q[1] <= pwdata[0];
    end else if (wr && paddr == 8'h20) begin
      mode_q[0] <= pwdata[0];
    end
  end
  sequence pulse_s;
    pin_oe[0] && pin_out[0];
  endsequence
  sequence held_s;
    (qb && lat_q && $stable(pin_in[0])) [*6];
  endsequence
  quasi_low_a: assert property (qb && !lat_q |=> pin_oe[0] && !pin_out[0]
    && !very_weak_pu_en[0]) else $error("quasi low drive wrong");
  very_weak_a: assert property (qb && lat_q |=> very_weak_pu_en[0])
    else $error("very weak pull-up off");
  weak_pu_a: assert property (held_s |=> weak_pu_en[0] == $past(pin_in[0]))
    else $error("weak pull-up wrong");
  strong_pulse_a: assert property (qb && $rose(lat_q) |=> pulse_s [*2] ##1 !pin_oe[0])
    else $error("strong pulse wrong");
  drain_mode_a: assert property (mode_q == `MODE_OPEN_DRAIN |=> pin_oe[0] == !$past(lat_q)
    && !pin_out[0] && !weak_pu_en[0] && !very_weak_pu_en[0]) else $error("drain wrong");
  push_pull_a: assert property (mode_q == `MODE_PUSH_PULL |=> pin_oe[0]
    && pin_out[0] == $past(lat_q)) else $error("push-pull wrong");
  input_only_a: assert property (mode_q == `MODE_INPUT_ONLY |=> !pin_oe[0]
    && !weak_pu_en[0] && !very_weak_pu_en[0]) else $error("input-only drives");
  reset_pin_a: assert property (!pin_oe[13] && !weak_pu_en[13] && !very_weak_pu_en[13])
    else $error("reset pin drives");
  i2c_pins_a: assert property (!(|(pin_oe[11:10] & pin_out[11:10])) && !(|weak_pu_en[11:10]))
    else $error("i2c pin drives high");
endmodule // io_port_checker
bind io_port_block io_port_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .paddr, .pwdata, .pin_in, .pin_out, .pin_oe, .weak_pu_en, .very_weak_pu_en);

/* pin_partner.sv */
`timescale 1ns/10ps
module pin_partner (
  input  logic [25:0] pin_out,
  input  logic [25:0] pin_oe,
  input  logic [25:0] ext_low,
  output logic [25:0] pin_in
);
  // Driven pins win; released pins sit on the board pull-up unless pulled low
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
endmodule // pin_partner

/* tb.sv */
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ext_reset_en = 1'b0, pready, pslverr, serr, oe, vw;
  logic [1:0]  clk_src_sel = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, r, e, seed = 32'ha2ed11f0;
  logic [25:0] pin_in, pin_out, pin_oe, weak_pu_en, very_weak_pu_en, digital_in_en;
  logic [25:0] ext_low = 26'h0;
  int          error_cnt = 0, total_checks = 0;
  io_port_block uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clk_src_sel, .ext_reset_en, .pin_in, .pin_out, .pin_oe, .weak_pu_en,
    .very_weak_pu_en, .digital_in_en);
  pin_partner far (.pin_out, .pin_oe, .ext_low, .pin_in);
  always #5 pclk = ~pclk;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n++ < 20) @(posedge pclk);
    if (pready !== 1'b1) error_cnt++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask
  task rst();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task close_out();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
  initial begin
    rst();
    for (int i = 0; i < 4; i++) begin
      rd(8'h10 + 8'(4 * i), i == 3 ? 32'h3 : 32'hff);
      rd(8'h20 + 8'(4 * i), 32'h0);
    end
    rd(8'h34, 32'd26);
    apb(1'b0, 8'h38, 32'h0);
    chk(32'(serr), 32'h1);
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        apb(1'b1, 8'h10, m[1] ? 32'hff : 32'h0);
        apb(1'b1, 8'h20, m[0] ? 32'hff : 32'h0);
        apb(1'b1, 8'h00, l ? 32'hff : 32'h0);
        repeat (8) @(posedge pclk);
        oe = (m == 1) || ((m == 0 || m == 3) && l == 0);
        vw = (m == 0) && (l == 1);
        chk(32'({pin_oe[0], pin_oe[0] & pin_out[0], very_weak_pu_en[0], weak_pu_en[0]}),
            32'({oe, oe & l[0], vw, vw}));
        rd(8'h00, oe && l == 0 ? 32'h0 : 32'hff);
        if (vw) begin
          ext_low[0] <= 1'b1;
          repeat (8) @(posedge pclk);
          chk(32'({weak_pu_en[0], very_weak_pu_en[0]}), 32'h1);
          rd(8'h00, 32'hfe);
          ext_low[0] <= 1'b0;
        end
      end
    end
    r = xs();
    apb(1'b1, 8'h14, r);
    rd(8'h14, {24'h0, r[7:0] | 8'h2c});
    apb(1'b1, 8'h24, r);
    rd(8'h24, {24'h0, r[7:0] & 8'hdf});
    rst();
    r = xs();
    ext_low <= r[25:0];
    r = xs();
    apb(1'b1, 8'h30, r);
    rd(8'h30, {24'h0, r[7:0] & 8'h3e});
    chk(32'(digital_in_en[7:0]), {24'h0, ~(r[7:0] & 8'h3e)});
    for (int p = 0; p < 4; p++) begin
      e = ~(ext_low >> (8 * p)) & (p == 3 ? 32'h3 : 32'hff);
      rd(8'(4 * p), p == 0 ? e & ~(r & 32'h3e) : e);
    end
    ext_low <= 26'h0;
    repeat (6) @(posedge pclk);
    ext_low[0] <= 1'b1;
    @(posedge pclk);
    ext_low[0] <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(8'h00, 32'hff & ~(r & 32'h3e));
    for (int k = 0; k < 6; k++) begin
      clk_src_sel <= 2'(k / 2);
      ext_reset_en <= k[0];
      rst();
      rd(8'h34, 32'(26 - k[0] - k / 2));
      rd(8'h30, 32'h0);
    end
    close_out();
  end
endmodule // tb
